// file: core/jfb_consts.svh
// Offsets, reset values and timing counts of the command and feedback block.
// Assumes inclusion by bare name; definitions only.
`ifndef JFB_CONSTS_SVH
`define JFB_CONSTS_SVH
`define JFB_CLK_PERIOD_NS 40
`define JFB_MS_NS 1000000
`define JFB_MS_CYCLES (`JFB_MS_NS / `JFB_CLK_PERIOD_NS)
`define JFB_OFS_CTRL 8'h00
`define JFB_OFS_RESP 8'h04
`define JFB_OFS_ADDR 8'h08
`define JFB_OFS_STAT 8'h0C
`define JFB_OFS_CMD_PGN 8'h10
`define JFB_OFS_CMD_TMO 8'h20
`define JFB_OFS_FB_PGN 8'h30
`define JFB_OFS_FB_RATE 8'h40
`define JFB_CMD_PGN_MOTOR 16'hEF00
`define JFB_CMD_PGN_POUT1 16'hFF06
`define JFB_CMD_PGN_POUT2 16'hFF07
`define JFB_CMD_PGN_MON 16'hFF08
`define JFB_FB_PGN_MOTOR 16'hFF0A
`define JFB_FB_PGN_POUT1 16'hFF0B
`define JFB_FB_PGN_POUT2 16'hFF0C
`define JFB_FB_PGN_MON 16'hFF0D
`define JFB_PGN_ADDR_CLAIM 16'hEE00
`define JFB_VENDOR_SCHEME_B_FRAME_HIGH 8'hFF
`define JFB_SA_DEFAULT 8'hCA
`define JFB_SA_MAX 8'hFD
`define JFB_SA_NULL 8'hFE
`define JFB_ECU_INST_DEFAULT 3'h0
`define JFB_BYTE_FILL 8'hFF
`define JFB_SCHEME_BASE 3'h2
`define JFB_RUN_INVALID 2'h3
`endif

// file: core/jfb_pkg.sv
// Types shared by the command and feedback block and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package jfb_pkg;
  typedef struct packed {
    logic [15:0] pgn;
    logic [7:0] addr;
    logic [63:0] data;
  } jfb_frame_t;
  typedef struct packed {
    logic [1:0] run;
    logic [15:0] rpm;
    logic [7:0] pct;
    logic [15:0] temp;
  } jfb_motor_stat_t;
  typedef struct packed {
    logic [1:0] run;
    logic [15:0] rpm;
    logic [7:0] pct;
    logic use_pct;
  } jfb_motor_cmd_t;
  typedef enum logic [1:0] {
    JFB_CH_MOTOR = 2'b00,
    JFB_CH_POUT1 = 2'b01,
    JFB_CH_POUT2 = 2'b10,
    JFB_CH_MON = 2'b11
  } jfb_chan_t;
endpackage

// file: core/jfb_cmd_feedback.sv
// Network command decoder, periodic feedback encoder and address claimer.
// Assumes a CAN controller on the same clock that hands over whole frames.
//
// What this block does
// - Proportional command word is current, 1 mA/bit
// - Digital-configured proportional output on when nonzero
// - Monitoring command word is voltage, 1 mV/bit
// - Configurable command PGN per channel with defaults
// - Response code zero: apply, send no reply
// - Per-channel command timeout, zero disables
// - Custom scheme moves command data to byte 2
// - Feedback PGN always in proprietary B range
// - Periodic feedback per channel, zero suppresses
// - Custom scheme feedback: bytes 0-1 0xFF
// - Motor feedback run state in bits 1..0
// - Motor feedback speed word, 0.5 rpm/bit
// - Motor feedback percent byte, 0.5 %/bit
// - Motor feedback temperature word, offset -273 C
// - Proportional feedback word is measured current
// - Monitoring feedback word is generated voltage
// - NAME arbitrary-address capable, configurable ECU instance
// - Source address default 202, range 0..253
// - Lost contention: try next higher address
// - Motor command run state in bits 1..0
// - Motor command speed word, 0.5 rpm/bit
// - Rpm command wins unless both bytes 0xFF
// - Ignore commands unless network control selected
`include "jfb_consts.svh"
module jfb_cmd_feedback #(
  parameter int MS_CYCLES = `JFB_MS_CYCLES,
  parameter logic [7:0] NAME_FUNCTION = 8'h5A, // Arbitrary value
  parameter logic [4:0] NAME_FUNC_INST = 5'h03, // Arbitrary value
  parameter logic [10:0] NAME_MAKER = 11'h3C1 // Arbitrary value
) (
  input wire logic clk, // 25 MHz system clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic rx_valid, // Received frame strobe
  input wire jfb_pkg::jfb_frame_t rx_frame, // Received frame, addr is sender
  output logic tx_valid, // Frame waiting for transmission
  output jfb_pkg::jfb_frame_t tx_frame, // Frame to send, addr is our source
  input wire logic tx_ready, // Controller takes the frame
  input wire logic [20:0] serial_number, // Unit serial, identity field
  input wire jfb_pkg::jfb_motor_stat_t motor_stat, // Measured motor state
  input wire logic [15:0] pout1_ma, // Measured current, output 1
  input wire logic [15:0] pout2_ma, // Measured current, output 2
  input wire logic [15:0] mon_mv, // Generated monitoring voltage
  output jfb_pkg::jfb_motor_cmd_t motor_cmd, // Motor command from network
  output logic [15:0] pout1_cmd_ma, // Current command, output 1
  output logic [15:0] pout2_cmd_ma, // Current command, output 2
  output logic [1:0] pout_dig_on, // Digital on state per proportional output
  output logic [15:0] mon_cmd_mv, // Voltage command, monitoring output
  output logic [3:0] cmd_timeout, // Timeout flag per channel
  output logic [7:0] source_addr, // Address currently claimed
  output logic cannot_claim // No free address left
);
  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] net_mode;
  logic [3:0] cmd_scheme;
  logic [3:0] fb_scheme;
  logic [1:0] pout_digital;
  logic [7:0] resp_code;
  logic [7:0] pref_addr;
  logic [2:0] ecu_inst;
  logic [15:0] cmd_pgn [4];
  logic [15:0] cmd_tmo [4];
  logic [15:0] fb_pgn [4];
  logic [15:0] fb_rate [4];
  logic [63:0] own_name;
  logic [3:0] accept;
  logic [3:0] fb_due;
  logic [3:0] fb_pending;
  logic [3:0] fb_send;
  logic claim_req;
  logic claim_send;
  logic ms_tick;
  logic [$clog2(MS_CYCLES)-1:0] ms_cnt;
  logic [2:0] cmd_base;
  logic [7:0] cmd_run_byte;
  logic tx_free;
  wire wr_hit = reg_wr;
  wire [1:0] reg_ch = reg_addr[3:2];
  wire claim_rx = rx_valid && rx_frame.pgn == `JFB_PGN_ADDR_CLAIM;

  function automatic logic [7:0] get_byte(input logic [63:0] d, input logic [2:0] idx);
    get_byte = d[{idx, 3'h0} +: 8];
  endfunction

  assign own_name = {1'b1, 3'h0, 4'h0, 7'h00, 1'b0, NAME_FUNCTION, NAME_FUNC_INST,
    ecu_inst, NAME_MAKER, serial_number};

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_ff @(posedge clk) begin
    if (rst) begin
      net_mode <= 4'h0;
      cmd_scheme <= 4'h0;
      fb_scheme <= 4'h0;
      pout_digital <= 2'h0;
      resp_code <= 8'h00;
      pref_addr <= `JFB_SA_DEFAULT;
      ecu_inst <= `JFB_ECU_INST_DEFAULT;
      cmd_pgn[0] <= `JFB_CMD_PGN_MOTOR;
      cmd_pgn[1] <= `JFB_CMD_PGN_POUT1;
      cmd_pgn[2] <= `JFB_CMD_PGN_POUT2;
      cmd_pgn[3] <= `JFB_CMD_PGN_MON;
      fb_pgn[0] <= `JFB_FB_PGN_MOTOR;
      fb_pgn[1] <= `JFB_FB_PGN_POUT1;
      fb_pgn[2] <= `JFB_FB_PGN_POUT2;
      fb_pgn[3] <= `JFB_FB_PGN_MON;
      for (int i = 0; i < 4; i++) begin
        cmd_tmo[i] <= 16'h0000;
        fb_rate[i] <= 16'h0000;
      end
    end else if (wr_hit) begin
      case (reg_addr & 8'hF0)
        `JFB_OFS_CTRL: begin
          case (reg_addr)
            `JFB_OFS_CTRL: begin
              net_mode <= reg_wdata[3:0];
              cmd_scheme <= reg_wdata[7:4];
              fb_scheme <= reg_wdata[11:8];
              pout_digital <= reg_wdata[13:12];
            end
            // Codes other than zero are stored but act as no response
            `JFB_OFS_RESP: resp_code <= reg_wdata[7:0];
            `JFB_OFS_ADDR: begin
              if (reg_wdata[7:0] <= `JFB_SA_MAX) begin
                pref_addr <= reg_wdata[7:0];
              end
              ecu_inst <= reg_wdata[10:8];
            end
            default: begin
            end
          endcase
        end
        `JFB_OFS_CMD_PGN: cmd_pgn[reg_ch] <= reg_wdata[15:0];
        `JFB_OFS_CMD_TMO: cmd_tmo[reg_ch] <= reg_wdata[15:0];
        // Only the low byte is kept: the high byte is forced on send
        `JFB_OFS_FB_PGN: fb_pgn[reg_ch] <= {`JFB_VENDOR_SCHEME_B_FRAME_HIGH, reg_wdata[7:0]};
        `JFB_OFS_FB_RATE: fb_rate[reg_ch] <= reg_wdata[15:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr & 8'hF0)
        `JFB_OFS_CTRL: begin
          case (reg_addr)
            `JFB_OFS_CTRL: reg_rdata <= {18'h0, pout_digital, fb_scheme, cmd_scheme, net_mode};
            `JFB_OFS_RESP: reg_rdata <= {24'h0, resp_code};
            `JFB_OFS_ADDR: reg_rdata <= {7'h0, cannot_claim, source_addr, 5'h0, ecu_inst,
              pref_addr};
            `JFB_OFS_STAT: reg_rdata <= {28'h0, cmd_timeout};
            default: reg_rdata <= 32'h0000_0000;
          endcase
        end
        `JFB_OFS_CMD_PGN: reg_rdata <= {16'h0, cmd_pgn[reg_ch]};
        `JFB_OFS_CMD_TMO: reg_rdata <= {16'h0, cmd_tmo[reg_ch]};
        `JFB_OFS_FB_PGN: reg_rdata <= {16'h0, fb_pgn[reg_ch]};
        `JFB_OFS_FB_RATE: reg_rdata <= {16'h0, fb_rate[reg_ch]};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond time base shared by timeouts and feedback intervals
  always_ff @(posedge clk) begin
    if (rst) begin
      ms_cnt <= '0;
      ms_tick <= 1'b0;
    end else if (ms_cnt == $bits(ms_cnt)'(MS_CYCLES - 1)) begin
      ms_cnt <= '0;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt <= ms_cnt + 1'b1;
      ms_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel acceptance, timeout and feedback interval
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      logic [15:0] tmo_cnt;
      logic [15:0] rate_cnt;
      assign accept[g] = rx_valid && net_mode[g] && rx_frame.pgn == cmd_pgn[g];
      always_ff @(posedge clk) begin
        if (rst) begin
          tmo_cnt <= 16'h0000;
          cmd_timeout[g] <= 1'b0;
        end else if (accept[g]) begin
          tmo_cnt <= 16'h0000;
          cmd_timeout[g] <= 1'b0;
        end else if (cmd_tmo[g] == 16'h0000) begin
          tmo_cnt <= 16'h0000;
          cmd_timeout[g] <= 1'b0;
        end else if (ms_tick && !cmd_timeout[g]) begin
          tmo_cnt <= tmo_cnt + 16'h0001;
          cmd_timeout[g] <= (tmo_cnt + 16'h0001) >= cmd_tmo[g];
        end
      end
      always_ff @(posedge clk) begin
        if (rst || fb_rate[g] == 16'h0000) begin
          rate_cnt <= 16'h0000;
          fb_due[g] <= 1'b0;
        end else if (ms_tick) begin
          fb_due[g] <= (rate_cnt + 16'h0001) >= fb_rate[g];
          rate_cnt <= ((rate_cnt + 16'h0001) >= fb_rate[g]) ? 16'h0000 : rate_cnt + 16'h0001;
        end else begin
          fb_due[g] <= 1'b0;
        end
      end
      // A new period arriving as the previous one is sent is kept
      always_ff @(posedge clk) begin
        if (rst) begin
          fb_pending[g] <= 1'b0;
        end else begin
          fb_pending[g] <= (fb_pending[g] & ~fb_send[g]) | (fb_due[g] & fb_rate[g] != 16'h0000);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Command decode; response code zero means apply and stay silent
  always_comb begin
    cmd_base = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (accept[i] && cmd_scheme[i]) begin
        cmd_base = `JFB_SCHEME_BASE;
      end
    end
  end

  assign cmd_run_byte = get_byte(rx_frame.data, cmd_base);

  always_ff @(posedge clk) begin
    if (rst) begin
      motor_cmd <= '0;
    end else if (accept[0]) begin
      if (cmd_run_byte[1:0] != `JFB_RUN_INVALID) begin
        motor_cmd.run <= cmd_run_byte[1:0];
      end
      motor_cmd.rpm <= {get_byte(rx_frame.data, cmd_base + 3'h2),
        get_byte(rx_frame.data, cmd_base + 3'h1)};
      motor_cmd.pct <= get_byte(rx_frame.data, cmd_base + 3'h3);
      motor_cmd.use_pct <= get_byte(rx_frame.data, cmd_base + 3'h1) == `JFB_BYTE_FILL &&
        get_byte(rx_frame.data, cmd_base + 3'h2) == `JFB_BYTE_FILL;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pout1_cmd_ma <= 16'h0000;
      pout2_cmd_ma <= 16'h0000;
      pout_dig_on <= 2'h0;
      mon_cmd_mv <= 16'h0000;
    end else begin
      if (accept[1]) begin
        pout1_cmd_ma <= {get_byte(rx_frame.data, cmd_base + 3'h1),
          get_byte(rx_frame.data, cmd_base)};
        pout_dig_on[0] <= pout_digital[0] && {get_byte(rx_frame.data, cmd_base + 3'h1),
          get_byte(rx_frame.data, cmd_base)} != 16'h0000;
      end
      if (accept[2]) begin
        pout2_cmd_ma <= {get_byte(rx_frame.data, cmd_base + 3'h1),
          get_byte(rx_frame.data, cmd_base)};
        pout_dig_on[1] <= pout_digital[1] && {get_byte(rx_frame.data, cmd_base + 3'h1),
          get_byte(rx_frame.data, cmd_base)} != 16'h0000;
      end
      if (accept[3]) begin
        mon_cmd_mv <= {get_byte(rx_frame.data, cmd_base + 3'h1),
          get_byte(rx_frame.data, cmd_base)};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address claim: lower NAME value wins contention
  always_ff @(posedge clk) begin
    if (rst) begin
      source_addr <= `JFB_SA_DEFAULT;
      cannot_claim <= 1'b0;
      claim_req <= 1'b1;
    end else if (wr_hit && reg_addr == `JFB_OFS_ADDR && reg_wdata[7:0] <= `JFB_SA_MAX) begin
      source_addr <= reg_wdata[7:0];
      cannot_claim <= 1'b0;
      claim_req <= 1'b1;
    end else if (claim_rx && rx_frame.addr == source_addr && !cannot_claim) begin
      if (rx_frame.data < own_name) begin
        if (source_addr == `JFB_SA_MAX) begin
          cannot_claim <= 1'b1;
          source_addr <= `JFB_SA_NULL;
        end else begin
          source_addr <= source_addr + 8'h01;
        end
      end
      claim_req <= 1'b1;
    end else if (claim_send) begin
      claim_req <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit: address claim first, then lowest pending feedback channel
  assign tx_free = !tx_valid || tx_ready;
  assign claim_send = tx_free && claim_req && !(claim_rx && rx_frame.addr == source_addr);

  always_comb begin
    fb_send = 4'h0;
    if (tx_free && !claim_req && !cannot_claim) begin
      for (int i = 3; i >= 0; i--) begin
        if (fb_pending[i]) begin
          fb_send = 4'h1 << i;
        end
      end
    end
  end

  function automatic logic [63:0] fb_data(input int ch, input logic scheme,
      input jfb_pkg::jfb_motor_stat_t ms, input logic [15:0] word);
    logic [63:0] d;
    logic [5:0] b;
    d = {8{`JFB_BYTE_FILL}};
    b = scheme ? 6'd16 : 6'd0;
    if (ch == 0) begin
      d[b +: 8] = {6'h00, ms.run};
      d[b + 6'd8 +: 16] = ms.rpm;
      d[b + 6'd24 +: 8] = ms.pct;
      d[b + 6'd32 +: 16] = ms.temp;
    end else begin
      d[b +: 16] = word;
    end
    fb_data = d;
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_frame <= '0;
    end else if (claim_send) begin
      tx_valid <= 1'b1;
      tx_frame.pgn <= `JFB_PGN_ADDR_CLAIM;
      tx_frame.addr <= source_addr;
      tx_frame.data <= own_name;
    end else if (fb_send != 4'h0) begin
      tx_valid <= 1'b1;
      tx_frame.addr <= source_addr;
      case (fb_send)
        4'h1: begin
          tx_frame.pgn <= {`JFB_VENDOR_SCHEME_B_FRAME_HIGH, fb_pgn[0][7:0]};
          tx_frame.data <= fb_data(0, fb_scheme[0], motor_stat, 16'h0000);
        end
        4'h2: begin
          tx_frame.pgn <= {`JFB_VENDOR_SCHEME_B_FRAME_HIGH, fb_pgn[1][7:0]};
          tx_frame.data <= fb_data(1, fb_scheme[1], motor_stat, pout1_ma);
        end
        4'h4: begin
          tx_frame.pgn <= {`JFB_VENDOR_SCHEME_B_FRAME_HIGH, fb_pgn[2][7:0]};
          tx_frame.data <= fb_data(2, fb_scheme[2], motor_stat, pout2_ma);
        end
        default: begin
          tx_frame.pgn <= {`JFB_VENDOR_SCHEME_B_FRAME_HIGH, fb_pgn[3][7:0]};
          tx_frame.data <= fb_data(3, fb_scheme[3], motor_stat, mon_mv);
        end
      endcase
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end
endmodule

// file: bench/jfb_can_peer.sv
// Far-side CAN peer: takes offered frames and injects received ones.
// Assumes the block's clock; the bench calls send and may set stall.
module jfb_can_peer (
  input wire logic clk, // System clock
  input wire logic tx_valid, // Block offers a frame
  input wire jfb_pkg::jfb_frame_t tx_frame, // Offered frame
  output logic tx_ready, // Controller takes the frame
  output logic rx_valid, // Received frame strobe
  output jfb_pkg::jfb_frame_t rx_frame // Received frame
);
  timeunit 1ns;
  timeprecision 100ps;
  jfb_pkg::jfb_frame_t got[$];
  logic stall = 1'b0;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_frame = '0;
  end
  // Random stalls stand in for lost bus arbitration
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_frame);
    tx_ready <= stall ? 1'($urandom_range(1)) : 1'b1;
  end
  task automatic send(input jfb_pkg::jfb_frame_t fr);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_frame <= fr;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_frame <= ~fr; // Stale bus content must not look valid
  endtask
endmodule

// file: bench/jfb_cmd_feedback_chk.sv
// Port-level checker of the command and feedback block.
// Assumes one clock and the synchronous reset of the block.
module jfb_cmd_feedback_chk (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic rx_valid, // Received frame strobe
  input wire logic reg_wr, // Write strobe
  input wire logic tx_valid, // Frame offered
  input wire logic tx_ready, // Frame taken
  input wire jfb_pkg::jfb_frame_t tx_frame, // Offered frame
  input wire logic [7:0] source_addr, // Claimed address
  input wire logic cannot_claim, // No address left
  input wire jfb_pkg::jfb_motor_cmd_t motor_cmd, // Motor command
  input wire logic [15:0] pout1_cmd_ma, // Output 1 current
  input wire logic [15:0] mon_cmd_mv, // Monitor voltage
  input wire logic [1:0] pout_dig_on, // Digital states
  input wire logic [3:0] cmd_timeout // Timeout flags
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_fb_range;
    tx_valid && tx_frame.pgn != 16'hEE00 |-> tx_frame.pgn[15:8] == 8'hFF;
  endproperty
  a_fb_range: assert property (p_fb_range) else $error("feedback pgn out of range");
  property p_sa_range;
    !cannot_claim |-> source_addr <= 8'hFD;
  endproperty
  a_sa_range: assert property (p_sa_range) else $error("source address above 253");
  property p_claim_step;
    $changed(source_addr) && !$past(reg_wr) |->
      source_addr == $past(source_addr) + 8'h01 || cannot_claim;
  endproperty
  a_claim_step: assert property (p_claim_step) else $error("address did not step by one");
  property p_dig_zero;
    pout1_cmd_ma == 16'h0000 |-> !pout_dig_on[0];
  endproperty
  a_dig_zero: assert property (p_dig_zero) else $error("digital on with zero command");
  property p_run_ok;
    motor_cmd.run != 2'b11;
  endproperty
  a_run_ok: assert property (p_run_ok) else $error("reserved run code applied");
  property p_cur_cause;
    $changed(pout1_cmd_ma) |-> $past(rx_valid);
  endproperty
  a_cur_cause: assert property (p_cur_cause) else $error("current changed without frame");
  property p_mv_cause;
    $changed(mon_cmd_mv) |-> $past(rx_valid);
  endproperty
  a_mv_cause: assert property (p_mv_cause) else $error("voltage changed without frame");
  property p_tmo_clear;
    $fell(cmd_timeout[3]) |-> $past(rx_valid) || $past(reg_wr, 2) || $past(rst);
  endproperty
  a_tmo_clear: assert property (p_tmo_clear) else $error("timeout cleared without cause");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("frame dropped before taken");
  property p_fill;
    tx_valid && tx_frame.pgn == 16'hFF0B |-> tx_frame.data[63:32] == 32'hFFFF_FFFF;
  endproperty
  a_fill: assert property (p_fill) else $error("unused bytes not filled");
  property p_first_claim;
    $fell(rst) |-> ##[0:2] (tx_valid && tx_frame.pgn == 16'hEE00 && tx_frame.data[63]);
  endproperty
  a_first_claim: assert property (p_first_claim) else $error("no claim after reset");
  c_tx: cover property (tx_valid && tx_ready && tx_frame.pgn == 16'hFF0A);
  c_sa: cover property ($changed(source_addr));
  c_tmo: cover property ($rose(cmd_timeout[3]));
endmodule
bind jfb_cmd_feedback jfb_cmd_feedback_chk i_jfb_cmd_feedback_chk (.*);

// file: bench/jfb_cmd_feedback_tb.sv
// Self-checking bench of the command and feedback block.
// Assumes the package, the peer model and the checker compile first.
module jfb_cmd_feedback_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] NF = 8'h21; // Arbitrary value
  localparam logic [4:0] NFI = 5'h07; // Arbitrary value
  localparam logic [10:0] NM = 11'h155; // Arbitrary value
  logic clk, rst, reg_wr, reg_rd, rx_valid, tx_valid, tx_ready, cannot_claim;
  logic [7:0] reg_addr, source_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [20:0] serial_number;
  logic [15:0] pout1_ma, pout2_ma, mon_mv, pout1_cmd_ma, pout2_cmd_ma, mon_cmd_mv, v, w;
  logic [1:0] pout_dig_on;
  logic [3:0] cmd_timeout;
  logic [63:0] d;
  jfb_pkg::jfb_frame_t rx_frame, tx_frame, f;
  jfb_pkg::jfb_motor_stat_t motor_stat;
  jfb_pkg::jfb_motor_cmd_t motor_cmd;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  // Short millisecond keeps timeout and rate runs brief
  jfb_cmd_feedback #(.MS_CYCLES(8), .NAME_FUNCTION(NF), .NAME_FUNC_INST(NFI), .NAME_MAKER(NM))
    i_jfb_cmd_feedback (.*);
  jfb_can_peer i_jfb_can_peer (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("checked=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= x;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic cmd(input logic [15:0] p, input logic [63:0] x);
    i_jfb_can_peer.send({p, 8'h33, x});
    #1;
  endtask
  task automatic get;
    for (n = 0; n < 200 && i_jfb_can_peer.got.size() == 0; n++) #40;
    if (i_jfb_can_peer.got.size() == 0) begin
      miscompares++;
      test_done();
    end else f = i_jfb_can_peer.got.pop_front();
  endtask
  task automatic claim(input logic [7:0] sa);
    get();
    chk({f.pgn, f.addr}, {16'hEE00, sa});
    chk(f.data, {16'h8000, NF, NFI, 3'h0, NM, serial_number});
  endtask
  function automatic logic [63:0] fb_of(input logic [15:0] p);
    if (p == 16'hFF0A)
      return {motor_stat.temp, motor_stat.pct, motor_stat.rpm, 6'h00, motor_stat.run, 16'hFFFF};
    if (p == 16'hFF0B) return {48'hFFFF_FFFF_FFFF, pout1_ma};
    return {48'hFFFF_FFFF_FFFF, mon_mv};
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hD92A));
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    serial_number = 21'($urandom);
    motor_stat = '0;
    pout1_ma = 16'h0;
    pout2_ma = 16'($urandom);
    mon_mv = 16'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1 chk(source_addr, 8'hCA);
    claim(8'hCA);
    for (int c = 0; c < 4; c++) begin
      rd(8'h10 + 8'(4 * c), (c == 0) ? 32'hEF00 : 32'hFF05 + c);
      rd(8'h30 + 8'(4 * c), 32'hFF0A + c);
    end
    rd(8'hFC, 32'h0);
    wr(8'h38, 32'h1234);
    rd(8'h38, 32'hFF34);
    rd(8'h08, 32'h00CA_00CA);
    wr(8'h00, 32'h104F);
    for (int k = 0; k < 4; k++) begin
      wr(8'h04, 32'h55 * (k % 3));
      v = (k == 3) ? 16'h0 : 16'($urandom);
      cmd(16'hFF06, {48'hFFFF_FFFF_FFFF, v});
      chk(pout1_cmd_ma, v);
      chk(pout_dig_on[0], v != 16'h0);
      #200 chk(i_jfb_can_peer.got.size(), 0);
    end
    v = 16'($urandom);
    cmd(16'hFF08, {48'hFFFF_FFFF_FFFF, v});
    chk(mon_cmd_mv, v);
    w = 16'($urandom);
    cmd(16'hFF07, {32'hFFFF_FFFF, w, 16'h1234});
    chk(pout2_cmd_ma, w);
    for (int r = 0; r < 4; r++) begin
      d = {32'hFFFF_FFFF, 8'($urandom), 1'b0, 15'($urandom), 8'(r)};
      cmd(16'hEF00, d);
      chk(motor_cmd, {(r == 3) ? 2'h2 : 2'(r), d[23:8], d[31:24], 1'b0});
    end
    cmd(16'hEF00, {32'hFFFF_FFFF, 8'h64, 16'hFFFF, 8'h01});
    chk({motor_cmd.use_pct, motor_cmd.pct, motor_cmd.run}, {1'b1, 8'h64, 2'h1});
    wr(8'h00, 32'h104D);
    cmd(16'hFF06, 64'h1111);
    chk(pout1_cmd_ma, 16'h0);
    wr(8'h1C, 32'hFF09);
    cmd(16'hFF08, 64'h3333);
    chk(mon_cmd_mv, v);
    cmd(16'hFF09, 64'h4444);
    chk(mon_cmd_mv, 16'h4444);
    wr(8'h2C, 32'd2);
    cmd(16'hFF09, 64'h0);
    for (n = 0; n < 40 && cmd_timeout[3] !== 1'b1; n++) #40;
    chk(n >= 7 && n <= 24, 1'b1);
    rd(8'h0C, 32'h8);
    cmd(16'hFF09, 64'h0);
    chk(cmd_timeout, 4'h0);
    wr(8'h2C, 32'd0);
    #1600 chk(cmd_timeout, 4'h0);
    @(posedge clk);
    motor_stat <= 42'({$urandom, $urandom});
    pout1_ma <= 16'($urandom);
    mon_mv <= 16'($urandom);
    i_jfb_can_peer.stall = 1'b1;
    wr(8'h00, 32'h010F);
    wr(8'h40, 32'd1);
    wr(8'h44, 32'd1);
    wr(8'h4C, 32'd1);
    for (int k = 0; k < 6; k++) begin
      get();
      chk({f.pgn[15:8], f.addr}, 16'hFFCA);
      d = (f.pgn == 16'hFF0A) ? 64'hFC_0000 : 64'h0;
      chk(f.data & ~d, fb_of(f.pgn));
    end
    wr(8'h40, 32'd0);
    wr(8'h44, 32'd0);
    wr(8'h4C, 32'd0);
    #800 i_jfb_can_peer.got.delete();
    i_jfb_can_peer.stall = 1'b0;
    #1600 chk(i_jfb_can_peer.got.size(), 0);
    i_jfb_can_peer.send({16'hEE00, 8'hCA, 64'h0});
    claim(8'hCB);
    chk(source_addr, 8'hCB);
    i_jfb_can_peer.send({16'hEE00, 8'hCB, 64'hFFFF_FFFF_FFFF_FFFF});
    claim(8'hCB);
    rd(8'h08, 32'h00CB_00CA);
    // Losing at the top address leaves the node without an address
    wr(8'h08, 32'hFD);
    claim(8'hFD);
    i_jfb_can_peer.send({16'hEE00, 8'hFD, 64'h0});
    claim(8'hFE);
    rd(8'h08, 32'h01FE_00FD);
    test_done();
  end
endmodule
